// ==== hw/rsu_pkg.sv ====
// Shared constants and types for the remote update controller and its fabric end
package rsu_pkg;
  // ------
  // Timing
  // ------
  localparam int CLK_HZ = 25_000_000;
  localparam int OSC_HZ = 10_000_000;
  localparam int OSC_DIV = CLK_HZ / OSC_HZ;
  localparam int OSC_W = $clog2(OSC_DIV + 1);
  localparam int LOAD_CYCLES = 64;
  localparam int LOAD_W = $clog2(LOAD_CYCLES);
  localparam int SCLK_HALF = 2;
  localparam int HALF_W = $clog2(SCLK_HALF + 1);
  localparam int REQ_NS = 200;
  localparam int REQ_CYCLES = (REQ_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int REQ_W = $clog2(REQ_CYCLES + 1);
  localparam int KICK_US = 1000;
  localparam int KICK_CYCLES = KICK_US * (CLK_HZ / 1_000_000);
  // ------
  // Control word and status
  // ------
  localparam int PAGE_W = 24;
  localparam int TIMER_W = 12;
  localparam int TIMER_LSB = 17;
  localparam int WD_W = TIMER_W + TIMER_LSB;
  localparam int STAT_W = 5;
  typedef struct packed {
    logic anf;
    logic [PAGE_W-1:0] page;
    logic wd_en;
    logic [TIMER_W-1:0] timer;
  } ctrl_t;
  localparam int CTRL_W = $bits(ctrl_t);
  localparam int SHIFT_W = STAT_W + CTRL_W;
  localparam int BIT_W = $clog2(SHIFT_W);
  localparam ctrl_t CTRL_RESET = '0;
  localparam int C_CRC = 0;
  localparam int C_CONFIG_ERROR_LINE = 1;
  localparam int C_FABRIC = 2;
  localparam int C_PIN_RESET = 3;
  localparam int C_WDOG = 4;
  localparam logic [STAT_W-1:0] CAUSE_FABRIC_ONLY = 5'h04;
  localparam int SY_CRC = 0;
  localparam int SY_NST = 1;
  localparam int SY_NCFG = 2;
  localparam logic [2:0] SYNC_RESET = 3'h6;
  // ------
  // Fabric-side registers
  // ------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] A_CMD = 8'h00;
  localparam logic [ADDR_W-1:0] A_CFG = 8'h04;
  localparam logic [ADDR_W-1:0] A_UPD_PAGE = 8'h08;
  localparam logic [ADDR_W-1:0] A_UPD_CTRL = 8'h0c;
  localparam logic [ADDR_W-1:0] A_CAP_PAGE = 8'h10;
  localparam logic [ADDR_W-1:0] A_CAP_CTRL = 8'h14;
  localparam logic [ADDR_W-1:0] A_IRQ_ST = 8'h18;
  localparam logic [ADDR_W-1:0] A_IRQ_MASK = 8'h1c;
  localparam int CMD_READ = 0;
  localparam int CMD_WRITE = 1;
  localparam int CMD_RECONF = 2;
  localparam int CMD_KICK = 3;
  localparam int F_WD_EN = 12;
  localparam int F_ANF = 13;
  localparam int F_STAT = 16;
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_USER = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ------
  // States
  // ------
  typedef enum logic [0:0] {D_LOAD = 1'b0, D_USER = 1'b1} dstate_t;
  typedef enum logic [1:0] {H_IDLE = 2'b00, H_LO = 2'b01, H_HI = 2'b10, H_REQ = 2'b11} hstate_t;
  typedef enum logic [1:0] {STG_CAP = 2'b00, STG_SHIFT = 2'b01, STG_COMMIT = 2'b10} stage_t;
endpackage

// ==== hw/rsu_if.sv ====
// Link between the update controller and the fabric logic
`timescale 1ns/1ns
interface rsu_if;
  logic upgrade_shift_clock;
  logic upgrade_serial_in;
  logic upgrade_serial_out;
  logic upgrade_shift_or_load;
  logic upgrade_capture_or_commit;
  logic fabric_reconfig_request_low;
  logic watchdog_clear_low;
  logic user_mode;
  modport device (
    input upgrade_shift_clock, upgrade_serial_in, upgrade_shift_or_load,
    input upgrade_capture_or_commit, fabric_reconfig_request_low, watchdog_clear_low,
    output upgrade_serial_out, user_mode
  );
  modport fabric (
    output upgrade_shift_clock, upgrade_serial_in, upgrade_shift_or_load,
    output upgrade_capture_or_commit, fabric_reconfig_request_low, watchdog_clear_low,
    input upgrade_serial_out, user_mode
  );
endinterface

// ==== hw/rsu_device.sv ====
// Dedicated remote update controller: loader state machine, registers, watchdog
`timescale 1ns/1ns
module rsu_device (
  input wire logic clk,
  input wire logic sys_rst,
  rsu_if.device link,
  input wire logic config_error_line_low,
  input wire logic crc_error,
  input wire logic config_reset_low,
  output logic [rsu_pkg::PAGE_W-1:0] image_page_address,
  output logic app_not_factory,
  output logic [rsu_pkg::STAT_W-1:0] reconfig_cause
);
  import rsu_pkg::*;

  // ------
  // Behaviour notes
  // ------
  // Serial frame is 43 bits, sent least significant bit first
  // Low 38 bits hold the control word, high 5 bits the status
  // A capture edge loads the frame, each shift edge moves it one bit
  // A commit edge copies the low 38 bits into the update word
  // Commit is ignored while an application image runs
  // Shift edges outside user mode are ignored
  // Serial out shows bit zero of the frame from the cycle after each edge
  // The shift clock is sampled on clk; a rise acts one cycle later
  // The fabric must hold each clock level one cycle or more
  // Faster toggling would be missed, not misread
  // Pin inputs pass two flops, so a pin event acts three cycles late
  // Pin pulses shorter than one clock may be lost
  // A load lasts a fixed count; errors during it restart the count
  // Status is rewritten on each reconfiguration, never accumulated
  // Several causes in one cycle each keep their own flag
  // A fabric request counts only on its falling edge in user mode
  // Fabric requests are ignored while a load is in progress
  // Only a factory request with no other cause loads the update word
  // Every other cause falls back to the factory image at page zero
  // The update word survives fall-backs until the factory rewrites it
  // Watchdog ticks come from a divider standing in for the oscillator
  // The divider ratio is truncated from 2.5 to 2, so time-outs run a fifth short
  // A zero timer field makes the watchdog expire at once
  // Holding the clear line low keeps the watchdog count at zero
  // The count is compared with the full time-out every cycle
  // so a new setting takes effect without a restart

  // ------
  // State
  // ------
  typedef struct packed {
    dstate_t st;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic sclk_prev;
    logic req_prev;
    logic sout;
    logic [SHIFT_W-1:0] shift;
    ctrl_t ctrl;
    ctrl_t upd;
    logic [STAT_W-1:0] status;
    logic [LOAD_W-1:0] load_cnt;
    logic [OSC_W-1:0] osc_cnt;
    logic [WD_W-1:0] wd_cnt;
  } dev_t;

  dev_t q;
  dev_t next_q;
  logic sclk_rise;
  logic osc_tick;
  logic wd_on;
  logic [WD_W-1:0] wd_limit;
  logic [STAT_W-1:0] cause;
  logic load_err;

  // ------
  // Outputs
  // ------
  assign image_page_address = q.ctrl.page;
  assign app_not_factory = q.ctrl.anf;
  assign reconfig_cause = q.status;
  assign link.upgrade_serial_out = q.sout;
  assign link.user_mode = (q.st == D_USER);

  // ------
  // Next state
  // ------
  // One state machine drives the registers and the watchdog
  always_comb begin
    next_q = q;
    sclk_rise = 1'b0;
    osc_tick = 1'b0;
    wd_on = 1'b0;
    wd_limit = '0;
    cause = '0;
    load_err = 1'b0;

    // Pins pass two flops before any use
    next_q.sync1 = {config_reset_low, config_error_line_low, crc_error};
    next_q.sync2 = q.sync1;
    next_q.sclk_prev = link.upgrade_shift_clock;
    next_q.req_prev = link.fabric_reconfig_request_low;
    sclk_rise = link.upgrade_shift_clock & ~q.sclk_prev;

    // Oscillator-rate tick for the watchdog
    osc_tick = (q.osc_cnt == OSC_W'(OSC_DIV - 1));
    next_q.osc_cnt = osc_tick ? '0 : q.osc_cnt + 1'b1;

    // Watchdog runs only for an enabled application image
    wd_on = (q.st == D_USER) & q.ctrl.anf & q.ctrl.wd_en;
    wd_limit = {q.ctrl.timer, {TIMER_LSB{1'b0}}};
    if (!wd_on || !link.watchdog_clear_low) begin
      next_q.wd_cnt = '0;
    end else if (osc_tick && q.wd_cnt < wd_limit) begin
      next_q.wd_cnt = q.wd_cnt + 1'b1;
    end

    // Every cause has its own flag
    cause[C_CRC] = q.sync2[SY_CRC];
    cause[C_CONFIG_ERROR_LINE] = ~q.sync2[SY_NST];
    cause[C_PIN_RESET] = ~q.sync2[SY_NCFG];
    cause[C_FABRIC] = (q.st == D_USER) & ~link.fabric_reconfig_request_low & q.req_prev;
    cause[C_WDOG] = wd_on & link.watchdog_clear_low & (q.wd_cnt >= wd_limit);
    load_err = cause[C_CRC] | cause[C_CONFIG_ERROR_LINE] | cause[C_PIN_RESET];

    unique case (q.st)
      D_LOAD: begin
        if (load_err) begin
          // Error while loading: fall back to the factory image
          next_q.status = cause;
          next_q.ctrl = CTRL_RESET;
          next_q.load_cnt = '0;
        end else if (q.load_cnt == LOAD_W'(LOAD_CYCLES - 1)) begin
          next_q.st = D_USER;
          next_q.load_cnt = '0;
        end else begin
          next_q.load_cnt = q.load_cnt + 1'b1;
        end
      end
      D_USER: begin
        if (|cause) begin
          next_q.status = cause;
          next_q.st = D_LOAD;
          next_q.load_cnt = '0;
          if (cause == CAUSE_FABRIC_ONLY && !q.ctrl.anf) begin
            // Factory request: load the page it prepared
            next_q.ctrl = q.upd;
          end else begin
            // Errors and application requests return to factory
            next_q.ctrl = CTRL_RESET;
          end
        end else if (sclk_rise) begin
          if (link.upgrade_shift_or_load) begin
            next_q.shift = {link.upgrade_serial_in, q.shift[SHIFT_W-1:1]};
          end else if (link.upgrade_capture_or_commit) begin
            // Factory sees the update word, an application its control word
            next_q.shift = {q.status, (q.ctrl.anf ? q.ctrl : q.upd)};
          end else if (!q.ctrl.anf) begin
            next_q.upd = q.shift[CTRL_W-1:0];
          end
        end
      end
    endcase
    next_q.sout = next_q.shift[0];
  end

  // ------
  // Registers
  // ------
  // Reset starts a factory load from page zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q.st <= D_LOAD;
      q.sync1 <= SYNC_RESET;
      q.sync2 <= SYNC_RESET;
      q.sclk_prev <= 1'b0;
      q.req_prev <= 1'b1;
      q.sout <= 1'b0;
      q.shift <= '0;
      q.ctrl <= CTRL_RESET;
      q.upd <= CTRL_RESET;
      q.status <= '0;
      q.load_cnt <= '0;
      q.osc_cnt <= '0;
      q.wd_cnt <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule // rsu_device

// ==== hw/rsu_fabric.sv ====
// Fabric end: AXI4-Lite registers driving the update controller's serial port
`timescale 1ns/1ns
module rsu_fabric #(
  parameter int KICK_CYCLES_P = rsu_pkg::KICK_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  rsu_if.fabric link,
  input wire logic awvalid,
  output logic awready,
  input wire logic [rsu_pkg::ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [rsu_pkg::ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic irq
);
  import rsu_pkg::*;
  localparam int KICK_W = $clog2(KICK_CYCLES_P + 1);

  // ------
  // State
  // ------
  typedef struct packed {
    hstate_t st;
    stage_t stage;
    logic wr_op;
    logic [BIT_W-1:0] bit_cnt;
    logic [HALF_W-1:0] half;
    logic [REQ_W-1:0] req_cnt;
    logic [KICK_W-1:0] kick_cnt;
    logic [SHIFT_W-1:0] rx;
    ctrl_t upd;
    ctrl_t cap;
    logic [STAT_W-1:0] cap_stat;
    logic [3:0] pend;
    logic auto_kick;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic um_prev;
    logic sclk, sin, sol, coc, req_low, clr_low;
    logic aw_got, w_got, awready, wready, bvalid, arready, rvalid;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [31:0] wmask;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
  } fab_t;

  fab_t q;
  fab_t next_q;
  logic [31:0] wv;
  logic [SHIFT_W-1:0] tx;
  logic done;

  assign link.upgrade_shift_clock = q.sclk;
  assign link.upgrade_serial_in = q.sin;
  assign link.upgrade_shift_or_load = q.sol;
  assign link.upgrade_capture_or_commit = q.coc;
  assign link.fabric_reconfig_request_low = q.req_low;
  assign link.watchdog_clear_low = q.clr_low;
  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign irq = q.irq;

  // ------
  // Next state
  // ------
  always_comb begin
    next_q = q;
    wv = '0;
    done = 1'b0;
    tx = {{STAT_W{1'b0}}, q.upd};
    next_q.um_prev = link.user_mode;
    next_q.clr_low = 1'b1;

    // Write channel: address and data in either order
    if (awvalid && q.awready) begin
      next_q.aw_got = 1'b1;
      next_q.awready = 1'b0;
      next_q.awaddr = awaddr;
    end
    if (wvalid && q.wready) begin
      next_q.w_got = 1'b1;
      next_q.wready = 1'b0;
      next_q.wdata = wdata;
      for (int i = 0; i < 4; i++) next_q.wmask[8*i +: 8] = {8{wstrb[i]}};
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      next_q.bvalid = 1'b1;
      next_q.bresp = RESP_OKAY;
      wv = q.wdata & q.wmask;
      unique case (q.awaddr)
        A_CMD: begin
          next_q.pend = q.pend | wv[3:0];
          if (wv[CMD_KICK]) next_q.clr_low = 1'b0;
        end
        A_CFG: next_q.auto_kick = q.wmask[0] ? wv[0] : q.auto_kick;
        A_UPD_PAGE: next_q.upd.page = (q.upd.page & ~q.wmask[PAGE_W-1:0]) | wv[PAGE_W-1:0];
        A_UPD_CTRL: begin
          if (q.wmask[0]) next_q.upd.timer[7:0] = wv[7:0];
          if (q.wmask[8]) next_q.upd.timer[TIMER_W-1:8] = wv[TIMER_W-1:8];
          if (q.wmask[8]) next_q.upd.wd_en = wv[F_WD_EN];
          if (q.wmask[8]) next_q.upd.anf = wv[F_ANF];
        end
        A_IRQ_ST: next_q.irq_st = q.irq_st & ~wv[IRQ_W-1:0];
        A_IRQ_MASK: next_q.irq_mask = (q.irq_mask & ~q.wmask[IRQ_W-1:0]) | wv[IRQ_W-1:0];
        A_CAP_PAGE, A_CAP_CTRL: next_q.bresp = RESP_OKAY;
        default: next_q.bresp = RESP_SLVERR;
      endcase
    end
    if (q.bvalid && bready) begin
      next_q.bvalid = 1'b0;
      next_q.aw_got = 1'b0;
      next_q.w_got = 1'b0;
      next_q.awready = 1'b1;
      next_q.wready = 1'b1;
    end

    // Read channel
    if (arvalid && q.arready) begin
      next_q.arready = 1'b0;
      next_q.rvalid = 1'b1;
      next_q.rresp = RESP_OKAY;
      unique case (araddr)
        A_CMD: next_q.rdata = {30'h0, (q.st != H_IDLE), link.user_mode};
        A_CFG: next_q.rdata = {31'h0, q.auto_kick};
        A_UPD_PAGE: next_q.rdata = {8'h00, q.upd.page};
        A_UPD_CTRL: next_q.rdata = {18'h0, q.upd.anf, q.upd.wd_en, q.upd.timer};
        A_CAP_PAGE: next_q.rdata = {8'h00, q.cap.page};
        A_CAP_CTRL: next_q.rdata = {11'h0, q.cap_stat, 2'h0, q.cap.anf, q.cap.wd_en, q.cap.timer};
        A_IRQ_ST: next_q.rdata = {30'h0, q.irq_st};
        A_IRQ_MASK: next_q.rdata = {30'h0, q.irq_mask};
        default: begin
          next_q.rdata = '0;
          next_q.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (q.rvalid && rready) begin
      next_q.rvalid = 1'b0;
      next_q.arready = 1'b1;
    end

    // Periodic health kick while enabled
    next_q.kick_cnt = q.auto_kick ? q.kick_cnt + 1'b1 : '0;
    if (q.auto_kick && q.kick_cnt == KICK_W'(KICK_CYCLES_P - 1)) begin
      next_q.kick_cnt = '0;
      next_q.clr_low = 1'b0;
    end

    // Serial port sequencer
    unique case (q.st)
      H_IDLE: begin
        if (link.user_mode && q.pend[CMD_READ]) begin
          next_q.pend[CMD_READ] = 1'b0;
          next_q.wr_op = 1'b0;
          next_q.stage = STG_CAP;
          next_q.st = H_LO;
        end else if (link.user_mode && q.pend[CMD_WRITE]) begin
          next_q.pend[CMD_WRITE] = 1'b0;
          next_q.wr_op = 1'b1;
          next_q.stage = STG_SHIFT;
          next_q.bit_cnt = '0;
          // An application word aimed at page zero is dropped
          next_q.st = (q.upd.anf && q.upd.page == '0) ? H_IDLE : H_LO;
          done = (q.upd.anf && q.upd.page == '0);
        end else if (link.user_mode && q.pend[CMD_RECONF]) begin
          next_q.pend[CMD_RECONF] = 1'b0;
          next_q.req_cnt = '0;
          next_q.req_low = 1'b0;
          next_q.st = H_REQ;
        end
      end
      H_LO: begin
        next_q.sol = (q.stage == STG_SHIFT);
        next_q.coc = (q.stage == STG_CAP);
        next_q.sin = q.wr_op & tx[q.bit_cnt];
        next_q.half = q.half + 1'b1;
        if (q.half == HALF_W'(SCLK_HALF - 1)) begin
          next_q.half = '0;
          next_q.sclk = 1'b1;
          next_q.st = H_HI;
          if (q.stage == STG_SHIFT) next_q.rx = {link.upgrade_serial_out, q.rx[SHIFT_W-1:1]};
        end
      end
      H_HI: begin
        next_q.half = q.half + 1'b1;
        if (q.half == HALF_W'(SCLK_HALF - 1)) begin
          next_q.half = '0;
          next_q.sclk = 1'b0;
          next_q.st = H_LO;
          if (q.stage == STG_CAP) begin
            next_q.stage = STG_SHIFT;
            next_q.bit_cnt = '0;
          end else if (q.stage == STG_SHIFT && q.bit_cnt != BIT_W'(SHIFT_W - 1)) begin
            next_q.bit_cnt = q.bit_cnt + 1'b1;
          end else if (q.stage == STG_SHIFT && q.wr_op) begin
            next_q.stage = STG_COMMIT;
          end else begin
            next_q.st = H_IDLE;
            done = 1'b1;
            if (!q.wr_op) begin
              next_q.cap = q.rx[CTRL_W-1:0];
              next_q.cap_stat = q.rx[SHIFT_W-1:CTRL_W];
            end
          end
        end
      end
      H_REQ: begin
        next_q.req_cnt = q.req_cnt + 1'b1;
        if (q.req_cnt == REQ_W'(REQ_CYCLES - 1)) begin
          next_q.req_low = 1'b1;
          next_q.st = H_IDLE;
          done = 1'b1;
        end
      end
    endcase

    // Device left user mode: abandon the transfer
    if (!link.user_mode && q.st != H_IDLE) begin
      next_q.st = H_IDLE;
      next_q.sclk = 1'b0;
      next_q.half = '0;
      next_q.req_low = 1'b1;
    end

    // Set wins over a same-cycle clear
    next_q.irq_st[IRQ_DONE] = next_q.irq_st[IRQ_DONE] | done;
    next_q.irq_st[IRQ_USER] = next_q.irq_st[IRQ_USER] | (link.user_mode & ~q.um_prev);
    next_q.irq = |(next_q.irq_st & next_q.irq_mask);
  end

  // ------
  // Registers
  // ------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
      q.st <= H_IDLE;
      q.stage <= STG_CAP;
      q.req_low <= 1'b1;
      q.clr_low <= 1'b1;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= next_q;
    end
  end
endmodule // rsu_fabric

// ==== verification/rsu_props.sv ====
// Checker for the update controller link and its status outputs
`timescale 1ns/1ns
module rsu_props (
  input logic clk,
  input logic sys_rst,
  input logic upgrade_shift_clock,
  input logic fabric_reconfig_request_low,
  input logic watchdog_clear_low,
  input logic user_mode,
  input logic crc_error,
  input logic [rsu_pkg::PAGE_W-1:0] image_page_address,
  input logic app_not_factory,
  input logic [rsu_pkg::STAT_W-1:0] reconfig_cause
);
  import rsu_pkg::*;
  // ----------
  // Assertions
  // ----------
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  reset_clear_a: assert property (disable iff (1'b0) sys_rst |=>
    image_page_address == '0 && !app_not_factory && reconfig_cause == '0 && !user_mode)
    else $error("state not cleared by reset");
  app_page_a: assert property (app_not_factory |-> image_page_address != '0)
    else $error("application running from page zero");
  fallback_page_a: assert property ($fell(app_not_factory) |-> image_page_address == '0)
    else $error("fall-back did not select page zero");
  wdog_app_only_a: assert property ($rose(reconfig_cause[C_WDOG]) |-> $past(app_not_factory))
    else $error("watchdog cause while factory image ran");
  // The fabric drops its request once the device has left user mode
  req_width_a: assert property ($fell(fabric_reconfig_request_low) |->
    !fabric_reconfig_request_low[*2] ##1 fabric_reconfig_request_low)
    else $error("reconfiguration request pulse width wrong");
  req_cause_a: assert property ($fell(fabric_reconfig_request_low) && user_mode |->
    ##[1:8] (!user_mode && reconfig_cause[C_FABRIC]))
    else $error("fabric request not acted on");
  load_gap_a: assert property ($fell(user_mode) |-> !user_mode[*8] ##[1:300] user_mode)
    else $error("image load length out of range");
  crc_fallback_a: assert property ($rose(crc_error) && app_not_factory |->
    ##[1:8] (!app_not_factory && reconfig_cause[C_CRC]))
    else $error("crc error did not reload factory image");
  shift_high_a: assert property ($rose(upgrade_shift_clock) |->
    upgrade_shift_clock[*2] ##1 !upgrade_shift_clock)
    else $error("shift clock high phase wrong");
  kick_pulse_a: assert property ($fell(watchdog_clear_low) |=> watchdog_clear_low)
    else $error("watchdog clear pulse too long");
  // Main scenarios reached
  cover property ($rose(user_mode) && app_not_factory);
  cover property ($rose(reconfig_cause[C_WDOG]));
  cover property ($fell(app_not_factory) && reconfig_cause == 5'h03);
endmodule // rsu_props

// ==== verification/remote_update_controller_tb_top.sv ====
// Bench joining the update controller and its fabric end
`timescale 1ns/1ns
module remote_update_controller_tb_top;
  import rsu_pkg::*;
  logic clk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq, app_not_factory;
  logic crc_error, config_error_line_low, config_reset_low;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [PAGE_W-1:0] image_page_address;
  logic [STAT_W-1:0] reconfig_cause;
  int mismatches = 0;
  int compares = 0;
  logic [2:0] pin_m [4] = '{3'h1, 3'h2, 3'h4, 3'h3};
  logic [4:0] pin_c [4] = '{5'h01, 5'h02, 5'h08, 5'h03};
  rsu_if link ();
  // -----------
  // Design ends
  // -----------
  rsu_device u_rsu_device (.clk(clk), .sys_rst(sys_rst), .link(link),
    .config_error_line_low(config_error_line_low), .crc_error(crc_error),
    .config_reset_low(config_reset_low), .image_page_address(image_page_address),
    .app_not_factory(app_not_factory), .reconfig_cause(reconfig_cause));
  rsu_fabric #(.KICK_CYCLES_P(200)) u_rsu_fabric (.clk(clk), .sys_rst(sys_rst), .link(link),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .irq(irq));
  rsu_props u_rsu_props (.clk(clk), .sys_rst(sys_rst),
    .upgrade_shift_clock(link.upgrade_shift_clock),
    .fabric_reconfig_request_low(link.fabric_reconfig_request_low),
    .watchdog_clear_low(link.watchdog_clear_low), .user_mode(link.user_mode),
    .crc_error(crc_error), .image_page_address(image_page_address),
    .app_not_factory(app_not_factory), .reconfig_cause(reconfig_cause));
  // Clock
  always #20 clk = ~clk;
  // -----
  // Tasks
  // -----
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bus write, address and data offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  // Bus read
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(d & m, e);
  endtask
  task automatic wait_um(input logic v);
    for (int n = 0; n < 4000 && link.user_mode !== v; n++) @(posedge clk);
  endtask
  // Issue a command and wait for it to finish
  task automatic run_cmd(input int b);
    logic [31:0] d;
    logic [1:0] r;
    d = '0;
    wr(A_CMD, 32'h1 << b);
    if (b == CMD_RECONF) begin
      wait_um(1'b0);
      wait_um(1'b1);
    end else if (b < CMD_RECONF) begin
      for (int n = 0; n < 500 && d[IRQ_DONE] !== 1'b1; n++) axi_rd(A_IRQ_ST, d, r);
      wr(A_IRQ_ST, 32'h1 << IRQ_DONE);
    end
  endtask
  // Factory sets the next image, then reconfigures
  task automatic go_app(input logic [23:0] p, input logic [31:0] c);
    wr(A_UPD_PAGE, {8'h0, p});
    wr(A_UPD_CTRL, c);
    run_cmd(CMD_WRITE);
    run_cmd(CMD_RECONF);
  endtask
  task automatic chk_dev(input logic [23:0] p, input logic a, input logic [4:0] c);
    chk({8'h0, image_page_address}, {8'h0, p});
    chk({31'h0, app_not_factory}, {31'h0, a});
    chk({27'h0, reconfig_cause}, {27'h0, c});
  endtask
  task automatic set_pins(input logic [2:0] m);
    @(posedge clk);
    crc_error <= m[0];
    config_error_line_low <= ~m[1];
    config_reset_low <= ~m[2];
  endtask
  task automatic end_test(input string s);
    $display("test %s finished", s);
  endtask
  task automatic tally_and_finish;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // -----
  // Tests
  // -----
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    clk = 1'b0;
    sys_rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    {config_error_line_low, config_reset_low, crc_error} = 3'b110;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    wait_um(1'b1);
    chk_dev(24'h0, 1'b0, 5'h00);
    rd_chk(A_IRQ_ST, 32'h3, 32'h2);
    chk({31'h0, irq}, 32'h0);
    wr(A_IRQ_MASK, 32'h3);
    rd_chk(A_IRQ_MASK, 32'h3, 32'h3);
    chk({31'h0, irq}, 32'h1);
    wr(A_IRQ_ST, 32'h2);
    rd_chk(A_IRQ_ST, 32'h3, 32'h0);
    chk({31'h0, irq}, 32'h0);
    end_test("power_up");
    run_cmd(CMD_READ);
    rd_chk(A_CAP_CTRL, 32'h1f_3fff, 32'h0);
    wr(A_CAP_PAGE, 32'hffff_ffff);
    rd_chk(A_CAP_PAGE, 32'hffff_ffff, 32'h0);
    axi_wr(8'h40, 32'h1, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    axi_rd(8'h40, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    end_test("factory_read");
    wr(A_CFG, 32'h1);
    go_app(24'hff0000, 32'h3001);
    chk_dev(24'hff0000, 1'b1, CAUSE_FABRIC_ONLY);
    wr(A_UPD_PAGE, 32'h0002_0000);
    run_cmd(CMD_WRITE);
    run_cmd(CMD_READ);
    rd_chk(A_CAP_PAGE, 32'hff_ffff, 32'hff_0000);
    rd_chk(A_CAP_CTRL, 32'h1f_3fff, 32'h4_3001);
    rd_chk(A_CMD, 32'h1, 32'h1);
    wr(A_CMD, 32'h1 << CMD_KICK);
    end_test("app_load");
    run_cmd(CMD_RECONF);
    chk_dev(24'h0, 1'b0, CAUSE_FABRIC_ONLY);
    end_test("app_request");
    wr(A_CFG, 32'h0);
    go_app(24'h030000, 32'h3000);
    wait_um(1'b0);
    wait_um(1'b1);
    chk_dev(24'h0, 1'b0, 5'h10);
    repeat (200) @(posedge clk);
    chk({31'h0, link.user_mode}, 32'h1);
    run_cmd(CMD_READ);
    rd_chk(A_CAP_CTRL, 32'h1f_0000, 32'h10_0000);
    wr(A_UPD_PAGE, 32'h0);
    wr(A_UPD_CTRL, 32'h2000);
    run_cmd(CMD_WRITE);
    run_cmd(CMD_READ);
    rd_chk(A_CAP_PAGE, 32'hff_ffff, 32'h03_0000);
    end_test("watchdog");
    for (int i = 0; i < 4; i++) begin
      go_app(24'h050000, 32'h2000);
      set_pins(pin_m[i]);
      repeat (8) @(posedge clk);
      set_pins(3'h0);
      wait_um(1'b1);
      chk_dev(24'h0, 1'b0, pin_c[i]);
    end
    end_test("error_causes");
    tally_and_finish();
  end
  // Hang guard
  initial begin
    #2_000_000;
    $display("watchdog expired");
    mismatches++;
    tally_and_finish();
  end
endmodule // remote_update_controller_tb_top
